/* core/iddc_pkg.sv */
package iddc_pkg;
    // Word and field widths
    localparam int WORD_W = 14;
    localparam int FILE_W = 7;
    localparam int BIT_W = 3;
    localparam int MASK_W = 8;
    localparam int LIT_W = 11;
    localparam int MODE_W = 2;
    localparam int CNT_W = 2;
    localparam int PH_W = 2;

    // Oscillator phases inside one instruction cycle
    localparam int OSC_PER_CYC = 4;
    localparam logic [PH_W-1:0] PH_FIRST = 2'h0;
    localparam logic [PH_W-1:0] PH_READ = 2'h1;
    localparam logic [PH_W-1:0] PH_LAST = 2'h3;
    localparam logic [PH_W-1:0] PH_WRITE = 2'h3;

    // Instruction cycle counts
    localparam logic [CNT_W-1:0] CYC_ZERO = 2'h0;
    localparam logic [CNT_W-1:0] CYC_ONE = 2'h1;
    localparam logic [CNT_W-1:0] CYC_TWO = 2'h2;

    // Direct register window and the two indirect ports in it
    localparam logic [FILE_W-1:0] FILE_LO = 7'h00;
    localparam logic [FILE_W-1:0] FILE_HI = 7'h7f;
    localparam logic [FILE_W-1:0] IND_PORT0 = 7'h00;
    localparam logic [FILE_W-1:0] IND_PORT1 = 7'h01;

    // Field positions
    localparam int D_POS = 7;
    localparam int BIT_LSB = 7;
    localparam int PTR_N_POS = 2;
    localparam int PTR_KN_POS = 6;

    // Group selects, top two bits
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    // Byte group, top six bits
    localparam logic [5:0] OPB_CTRL = 6'h00;
    localparam logic [5:0] OPB_CLR = 6'h01;
    localparam logic [5:0] OPB_DEC_SKIP = 6'h0b;
    localparam logic [5:0] OPB_INC_SKIP = 6'h0f;
    // Bit group, top four bits
    localparam logic [3:0] OPT_SKIP_ZERO = 4'h6;
    localparam logic [3:0] OPT_SKIP_ONE = 4'h7;
    // Literal and control group
    localparam logic [2:0] OPL_SUB_JUMP = 3'h4;
    localparam logic [2:0] OPL_ABS_JUMP = 3'h5;
    localparam logic [4:0] OPL_REL_JUMP = 5'h19;
    localparam logic [5:0] OPL_EXIT_LIT = 6'h34;
    localparam logic [5:0] OPL_PTR_K = 6'h3f;
    // Control words, low seven bits
    localparam logic [6:0] CT_EXIT = 7'h08;
    localparam logic [6:0] CT_INT_EXIT = 7'h09;
    localparam logic [6:0] CT_SUB_ACC = 7'h0a;
    localparam logic [6:0] CT_JUMP_ACC = 7'h0b;
    localparam logic [2:0] CT_PTR_HI = 3'h1;

    typedef enum logic [3:0] {
        CL_NOP, CL_FILE, CL_BIT, CL_LIT, CL_SUB, CL_EXIT, CL_JUMP, CL_SKIP,
        CL_PTR
    } iddc_class_e;

    typedef enum logic {ST_RUN, ST_FLUSH} iddc_state_e;
endpackage

/* core/iddc_phase_div.sv */
`timescale 1ns/1ps
`default_nettype none
module iddc_phase_div
    import iddc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    output logic [PH_W-1:0] phase_q,
    output logic cycle_end
);
    logic [PH_W-1:0] phase_d;

    // Next oscillator phase, wrapping after the last one
    always_comb
    begin
        phase_d = phase_q;
        if (ce)
        begin
            phase_d = (phase_q == PH_LAST) ? PH_FIRST : phase_q + 2'h1;
        end
    end

    // Phase register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            phase_q <= PH_FIRST;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end

    assign cycle_end = ce && (phase_q == PH_LAST); // RULE_07

    // Four enabled clocks make one instruction cycle
    AST_PHASE_WRAP: assert property ( // RULE_07
        @(posedge clk iff ce) disable iff (reset)
        (phase_q == PH_LAST) |=> (phase_q == PH_FIRST) ##3
        (phase_q == PH_LAST))
        else $error("Instruction cycle is not four clocks");
endmodule
`default_nettype wire

/* core/iddc_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: Each instruction is one 14-bit word with opcode and all operands.
// RULE_02: Every instruction takes one cycle unless listed as longer.
// RULE_03: Subroutine jumps, direct or via accumulator, take two cycles.
// RULE_04: Every kind of return takes two cycles.
// RULE_05: Jumps, relative jumps, accumulator jumps and skips take two cycles.
// RULE_06: Indirect access through a program-memory pointer adds one cycle.
// RULE_07: One instruction cycle is four oscillator clocks.
// RULE_08: Any file register operand is read, modified, then stored; bit-test skips read the register and store nothing.
// RULE_09: Destination bit zero writes accumulator, one writes the register.
// RULE_10: File address selects a register in window 0x00 to 0x7f.
// RULE_11: Bit address picks one bit of the eight-bit register.
// RULE_12: Pointer number selects pointer zero or one and its port.
// RULE_13: Two-bit mode selects pre/post increment/decrement of the pointer.
// RULE_14: Don't-care instruction bits never change the decode.
// RULE_15: Literal field goes straight to datapath or program counter.
// RULE_16: Extra cycles execute as no-ops with the prefetch discarded.
module iddc_decoder
    import iddc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [WORD_W-1:0] instr_word,
    input wire logic [1:0] ptr_prog,
    output logic fetch_take,
    output logic [PH_W-1:0] phase_q,
    output logic cycle_end,
    output logic exec_nop_q,
    output iddc_class_e op_class_q,
    output logic [FILE_W-1:0] file_addr_q,
    output logic [BIT_W-1:0] bit_addr_q,
    output logic [MASK_W-1:0] bit_mask_q,
    output logic dest_file_q,
    output logic ptr_num_q,
    output logic [MODE_W-1:0] ptr_mode_q,
    output logic [LIT_W-1:0] literal_q,
    output logic file_rd,
    output logic file_wr,
    output logic acc_wr,
    output logic pc_load
);
    iddc_state_e state_q, state_d;
    logic [CNT_W-1:0] rem_q, rem_d;
    iddc_class_e class_n, op_class_d;
    logic [FILE_W-1:0] file_addr_d;
    logic [BIT_W-1:0] bit_addr_d;
    logic [MASK_W-1:0] bit_mask_d;
    logic dest_file_n, dest_file_d;
    logic ptr_num_n, ptr_num_d;
    logic [MODE_W-1:0] ptr_mode_d;
    logic [LIT_W-1:0] literal_n, literal_d;
    logic names_file_n, names_file_q, names_file_d;
    logic writes_n, writes_q, writes_d;
    logic ind_ref_n;
    logic [CNT_W-1:0] total_n;
    logic load;
    logic running;

    // Oscillator phase divider
    iddc_phase_div u_phase (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .phase_q(phase_q),
        .cycle_end(cycle_end)
    );

    // Decode of the fetched word
    always_comb
    begin
        class_n = CL_NOP;
        dest_file_n = instr_word[D_POS]; // RULE_09
        names_file_n = 1'b0;
        writes_n = 1'b0;
        ptr_num_n = instr_word[PTR_N_POS]; // RULE_12
        literal_n = instr_word[LIT_W-1:0]; // RULE_15
        ind_ref_n = 1'b0;
        // Whole word carries opcode and operands
        if (instr_word[WORD_W-1 -: 2] == GRP_BYTE) // RULE_01
        begin
            if (instr_word[WORD_W-1 -: 6] == OPB_CTRL && !instr_word[D_POS])
            begin
                if (instr_word[6:0] == CT_EXIT
                    || instr_word[6:0] == CT_INT_EXIT)
                begin
                    class_n = CL_EXIT; // RULE_04
                end
                else if (instr_word[6:0] == CT_SUB_ACC)
                begin
                    class_n = CL_SUB; // RULE_03
                end
                else if (instr_word[6:0] == CT_JUMP_ACC)
                begin
                    class_n = CL_JUMP; // RULE_05
                end
                else if (instr_word[6:4] == CT_PTR_HI)
                begin
                    class_n = CL_PTR; // RULE_12
                    ind_ref_n = 1'b1;
                    dest_file_n = instr_word[3];
                    writes_n = 1'b1;
                end
            end
            else if (instr_word[WORD_W-1 -: 6] == OPB_CLR
                && !instr_word[D_POS])
            begin
                // Accumulator clear: low bits are don't-care
                class_n = CL_LIT; // RULE_14
                writes_n = 1'b1;
            end
            else
            begin
                class_n = (instr_word[WORD_W-1 -: 6] == OPB_DEC_SKIP
                    || instr_word[WORD_W-1 -: 6] == OPB_INC_SKIP)
                    ? CL_SKIP : CL_FILE; // RULE_05
                names_file_n = 1'b1; // RULE_08
                writes_n = 1'b1;
            end
        end
        else if (instr_word[WORD_W-1 -: 2] == GRP_BIT)
        begin
            class_n = (instr_word[WORD_W-1 -: 4] == OPT_SKIP_ZERO
                || instr_word[WORD_W-1 -: 4] == OPT_SKIP_ONE)
                ? CL_SKIP : CL_BIT; // RULE_05
            names_file_n = 1'b1; // RULE_08
            writes_n = (class_n == CL_BIT);
            dest_file_n = 1'b1;
        end
        else if (instr_word[WORD_W-1 -: 3] == OPL_SUB_JUMP)
        begin
            class_n = CL_SUB; // RULE_03
        end
        else if (instr_word[WORD_W-1 -: 3] == OPL_ABS_JUMP)
        begin
            class_n = CL_JUMP; // RULE_05
        end
        else if (instr_word[WORD_W-1 -: 5] == OPL_REL_JUMP)
        begin
            class_n = CL_JUMP; // RULE_05
        end
        else if (instr_word[WORD_W-1 -: 6] == OPL_EXIT_LIT)
        begin
            class_n = CL_EXIT; // RULE_04
            writes_n = 1'b1;
            dest_file_n = 1'b0;
        end
        else if (instr_word[WORD_W-1 -: 6] == OPL_PTR_K)
        begin
            class_n = CL_PTR; // RULE_12
            ind_ref_n = 1'b1;
            ptr_num_n = instr_word[PTR_KN_POS];
            dest_file_n = instr_word[D_POS];
            writes_n = 1'b1;
        end
        else
        begin
            class_n = CL_LIT; // RULE_15
            writes_n = 1'b1;
            dest_file_n = 1'b0;
        end
        // Direct operand hitting an indirect port
        if (names_file_n && (instr_word[FILE_W-1:0] == IND_PORT0
            || instr_word[FILE_W-1:0] == IND_PORT1))
        begin
            ind_ref_n = 1'b1;
            ptr_num_n = instr_word[0];
        end
        // Cycle count: one by default, two for flow changes
        total_n = CYC_ONE; // RULE_02
        if (class_n == CL_SUB || class_n == CL_EXIT
            || class_n == CL_JUMP || class_n == CL_SKIP)
        begin
            total_n = CYC_TWO; // RULE_03 RULE_04 RULE_05
        end
        if (ind_ref_n && ptr_prog[ptr_num_n])
        begin
            total_n = total_n + CYC_ONE; // RULE_06
        end
    end

    assign load = cycle_end && (rem_q == CYC_ZERO);
    assign fetch_take = load;
    assign running = (state_q == ST_RUN);

    // Sequencer and operand latches
    always_comb
    begin
        state_d = state_q;
        rem_d = rem_q;
        op_class_d = op_class_q;
        file_addr_d = file_addr_q;
        bit_addr_d = bit_addr_q;
        bit_mask_d = bit_mask_q;
        dest_file_d = dest_file_q;
        ptr_num_d = ptr_num_q;
        ptr_mode_d = ptr_mode_q;
        literal_d = literal_q;
        names_file_d = names_file_q;
        writes_d = writes_q;
        if (load)
        begin
            state_d = ST_RUN;
            rem_d = total_n - CYC_ONE;
            op_class_d = class_n;
            file_addr_d = instr_word[FILE_W-1:0]; // RULE_10
            bit_addr_d = instr_word[BIT_LSB +: BIT_W]; // RULE_11
            bit_mask_d = MASK_W'(8'h01 << instr_word[BIT_LSB +: BIT_W]);
            dest_file_d = dest_file_n; // RULE_09
            ptr_num_d = ptr_num_n; // RULE_12
            ptr_mode_d = instr_word[MODE_W-1:0]; // RULE_13
            literal_d = literal_n; // RULE_15
            names_file_d = names_file_n;
            writes_d = writes_n;
        end
        else if (cycle_end)
        begin
            // Prefetched word is dropped, cycle runs empty
            state_d = ST_FLUSH; // RULE_16
            rem_d = rem_q - CYC_ONE;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= ST_FLUSH;
            rem_q <= CYC_ZERO;
            op_class_q <= CL_NOP;
            file_addr_q <= FILE_LO;
            bit_addr_q <= '0;
            bit_mask_q <= '0;
            dest_file_q <= 1'b0;
            ptr_num_q <= 1'b0;
            ptr_mode_q <= '0;
            literal_q <= '0;
            names_file_q <= 1'b0;
            writes_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rem_q <= rem_d;
            op_class_q <= op_class_d;
            file_addr_q <= file_addr_d;
            bit_addr_q <= bit_addr_d;
            bit_mask_q <= bit_mask_d;
            dest_file_q <= dest_file_d;
            ptr_num_q <= ptr_num_d;
            ptr_mode_q <= ptr_mode_d;
            literal_q <= literal_d;
            names_file_q <= names_file_d;
            writes_q <= writes_d;
        end
    end

    assign exec_nop_q = !running; // RULE_16

    // Strobes: read early, store late, none in empty cycles
    assign file_rd = ce && running && names_file_q
        && (phase_q == PH_READ); // RULE_08
    assign file_wr = ce && running && writes_q && dest_file_q
        && (phase_q == PH_WRITE); // RULE_09
    assign acc_wr = ce && running && writes_q && !dest_file_q
        && (phase_q == PH_WRITE); // RULE_09
    assign pc_load = ce && running && (phase_q == PH_WRITE)
        && (op_class_q == CL_SUB || op_class_q == CL_JUMP); // RULE_15

    AST_ONE_CYCLE: assert property ( // RULE_02
        @(posedge clk iff ce) disable iff (reset)
        (load && total_n == CYC_ONE) |-> ##4 load)
        else $error("Single-cycle instruction overran");

    AST_TWO_CYCLE: assert property ( // RULE_03
        @(posedge clk iff ce) disable iff (reset)
        (load && total_n == CYC_TWO) |-> ##4 !load ##4 load)
        else $error("Two-cycle instruction has wrong length");

    AST_FLOW_TWO: assert property ( // RULE_05
        @(posedge clk iff ce) disable iff (reset)
        (load && (class_n == CL_SKIP || class_n == CL_JUMP
            || class_n == CL_EXIT)) |-> (total_n >= CYC_TWO))
        else $error("Flow change not given two cycles");

    AST_IND_EXTRA: assert property ( // RULE_06
        @(posedge clk iff ce) disable iff (reset)
        (load && total_n == CYC_TWO + CYC_ONE) |-> ##4 !load ##4 !load ##4 load)
        else $error("Indirect program access lacks extra cycle");

    AST_READ_FIRST: assert property ( // RULE_08
        @(posedge clk iff ce) disable iff (reset)
        (file_wr && names_file_q) |-> $past(file_rd, 2))
        else $error("File register stored without prior read");

    AST_DEST_SPLIT: assert property ( // RULE_09
        @(posedge clk iff ce) disable iff (reset)
        !(file_wr && acc_wr) && !(acc_wr && dest_file_q))
        else $error("Result routed to wrong destination");

    AST_BIT_MASK: assert property ( // RULE_11
        @(posedge clk iff ce) disable iff (reset)
        load |=> $onehot(bit_mask_q)
            && bit_mask_q[bit_addr_q])
        else $error("Bit mask does not match bit address");

    AST_FLUSH_QUIET: assert property ( // RULE_16
        @(posedge clk iff ce) disable iff (reset)
        exec_nop_q |-> !file_rd && !file_wr && !acc_wr && !pc_load)
        else $error("State changed during an empty cycle");
endmodule
`default_nettype wire

/* verification/iddc_pmem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iddc_pmem_model
    import iddc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic fetch_take,
    input wire logic file_rd,
    input wire logic load_en,
    input wire logic [7:0] load_addr,
    input wire logic [WORD_W-1:0] load_data,
    output logic [WORD_W-1:0] instr_word,
    output logic [15:0] rd_cnt
);
    logic [WORD_W-1:0] mem [256];
    logic [7:0] pc_q;

    // Whole word at the program counter, unloaded places stay unknown
    assign instr_word = mem[pc_q];

    // Program load, counter advance on each taken word, file read tally
    always_ff @(posedge clk)
    begin
        if (load_en)
            mem[load_addr] <= load_data;
        if (reset)
        begin
            pc_q <= 8'h00;
            rd_cnt <= 16'h0000;
        end
        else
        begin
            if (fetch_take)
                pc_q <= pc_q + 8'h01;
            if (file_rd)
                rd_cnt <= rd_cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import iddc_pkg::*;
;
    typedef struct {int kind; int cyc; int rd; int fw; int aw; int pl;}
        iddc_exp_s;
    localparam int N = 24;
    logic clk, reset, ce, load_en, fetch_take, cycle_end, exec_nop_q;
    logic file_rd, file_wr, acc_wr, pc_load, dest_file_q, ptr_num_q;
    logic [1:0] ptr_prog;
    logic [7:0] load_addr;
    logic [WORD_W-1:0] load_data, instr_word;
    logic [PH_W-1:0] phase_q;
    iddc_class_e op_class_q;
    logic [FILE_W-1:0] file_addr_q;
    logic [BIT_W-1:0] bit_addr_q;
    logic [MASK_W-1:0] bit_mask_q;
    logic [MODE_W-1:0] ptr_mode_q;
    logic [LIT_W-1:0] literal_q;
    logic [15:0] rd_cnt;
    logic [13:0] prog [N];
    int seed = 95;
    int n_errors = 0;
    int total_checks = 0;

    iddc_decoder dut (.clk(clk), .reset(reset), .ce(ce),
        .instr_word(instr_word), .ptr_prog(ptr_prog),
        .fetch_take(fetch_take), .phase_q(phase_q), .cycle_end(cycle_end),
        .exec_nop_q(exec_nop_q), .op_class_q(op_class_q),
        .file_addr_q(file_addr_q), .bit_addr_q(bit_addr_q),
        .bit_mask_q(bit_mask_q), .dest_file_q(dest_file_q),
        .ptr_num_q(ptr_num_q), .ptr_mode_q(ptr_mode_q),
        .literal_q(literal_q), .file_rd(file_rd), .file_wr(file_wr),
        .acc_wr(acc_wr), .pc_load(pc_load));

    iddc_pmem_model pmem (.clk(clk), .reset(reset), .fetch_take(fetch_take),
        .file_rd(file_rd), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .instr_word(instr_word), .rd_cnt(rd_cnt));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One falling edge, random stall, then let outputs settle
    task step;
        @(negedge clk);
        ce = ($random(seed) % 5) != 0;
        #1;
    endtask

    // Cycles, strobes and field kind expected for one word
    function automatic iddc_exp_s expect_of(input logic [13:0] w,
        input logic [1:0] pp);
        iddc_exp_s e;
        int ind;
        e = '{0, 1, 0, 0, 0, 0};
        ind = 0;
        if (w[13:12] == GRP_BYTE && (w[13:8] > OPB_CLR || w[7]))
        begin
            e = '{1, 1, 1, w[7], !w[7], 0};
            ind = int'(w[6:1] == 6'h00 && pp[w[0]]);
            if (w[13:8] == OPB_DEC_SKIP || w[13:8] == OPB_INC_SKIP)
                e = '{1, 2, 1, -1, -1, -1};
        end
        else if (w[13:12] == GRP_BIT)
        begin
            if (w[11])
                e = '{2, 2, 1, 0, 0, -1};
            else
                e = '{2, 1, 1, 1, 0, 0};
            ind = int'(w[6:1] == 6'h00 && pp[w[0]]);
        end
        else if (w[13:8] == OPB_CLR)
            e.aw = 1;
        else if (w[13:4] == 10'h001 || w[13:8] == OPL_PTR_K)
        begin
            e = '{3, 1, -1, -1, -1, -1};
            ind = int'(pp[(w[13:8] == OPL_PTR_K) ? w[6] : w[2]]);
        end
        else if (w[13:12] == GRP_BYTE)
        begin
            if (w[13:2] == 12'h002)
                e = '{0, 2, 0, 0, -1, w[1] ? 1 : -1};
        end
        else if (w[13:11] == OPL_SUB_JUMP || w[13:11] == OPL_ABS_JUMP ||
            w[13:9] == OPL_REL_JUMP)
            e = '{0, 2, 0, 0, 0, 1};
        else if (w[13:8] == OPL_EXIT_LIT)
            e = '{0, 2, 0, 0, -1, -1};
        else
            e.aw = -1;
        e.cyc = e.cyc + ind;
        return e;
    endfunction

    // Corner words first, then random words of every group
    function automatic logic [13:0] make_word(input int k,
        input logic [31:0] r);
        logic [13:0] c [20];
        c = '{14'h0000, 14'h0008, 14'h0009, 14'h000a, 14'h000b, 14'h017f,
            14'h077f, 14'h0780, 14'h0b81, 14'h1f80, 14'h147f, 14'h27ff,
            14'h2fff, 14'h33ff, 14'h3455, 14'h0016, 14'h3f7f, 14'h30aa,
            14'h00a1, 14'h0181};
        if (k < 20)
            return c[k];
        case (r[31:28] % 10)
            0: return {6'(2 + r[11:8] % 14), r[7:0]};
            1: return {GRP_BIT, r[11:0]};
            2: return {2'h2, r[11:0]};
            3: return {OPL_REL_JUMP, r[8:0]};
            4: return {OPL_EXIT_LIT, r[7:0]};
            5: return {6'h30, r[7:0]};
            6: return {OPB_CLR, 1'b0, r[6:0]};
            7: return {10'h001, r[3:0]};
            8: return {OPL_PTR_K, r[7:0]};
            default: return {12'h002, r[1:0]};
        endcase
    endfunction

    // Class each word should decode to
    function automatic iddc_class_e class_of(input logic [13:0] w);
        if (w[13:12] == GRP_BIT)
            return w[11] ? CL_SKIP : CL_BIT;
        if (w[13:12] == GRP_BYTE && (w[13:8] > OPB_CLR || w[7]))
            return (w[13:8] == OPB_DEC_SKIP || w[13:8] == OPB_INC_SKIP)
                ? CL_SKIP : CL_FILE;
        if (w[13:8] == OPB_CLR)
            return CL_LIT;
        if (w[13:4] == 10'h001 || w[13:8] == OPL_PTR_K)
            return CL_PTR;
        if (w[13:2] == 12'h002)
            return w[1] ? (w[0] ? CL_JUMP : CL_SUB) : CL_EXIT;
        if (w[13:12] == GRP_BYTE)
            return CL_NOP;
        if (w[13:11] == OPL_SUB_JUMP)
            return CL_SUB;
        if (w[13:11] == OPL_ABS_JUMP || w[13:9] == OPL_REL_JUMP)
            return CL_JUMP;
        return (w[13:8] == OPL_EXIT_LIT) ? CL_EXIT : CL_LIT;
    endfunction

    task check_fields(input logic [13:0] w, input iddc_exp_s e);
        chk(op_class_q, class_of(w));
        chk(literal_q, w[10:0]);
        chk(ptr_mode_q, w[1:0]);
        if (e.kind == 1 || e.kind == 2)
            chk(file_addr_q, w[6:0]);
        if (e.kind == 1)
            chk(dest_file_q, w[7]);
        if (e.kind == 2)
            chk({bit_addr_q, bit_mask_q}, {w[9:7], 8'h01 << w[9:7]});
        if (e.kind == 3)
            chk(ptr_num_q, (w[13:8] == OPL_PTR_K) ? w[6] : w[2]);
    endtask

    // Follow one instruction from its load to the next load
    task automatic run_one(input logic [13:0] w, input logic [1:0] pp);
        iddc_exp_s e;
        int cnt;
        int i;
        logic [3:0] fw, aw, pl;
        logic [15:0] rd0;
        e = expect_of(w, pp);
        cnt = 0;
        fw = 4'h0;
        aw = 4'h0;
        pl = 4'h0;
        rd0 = rd_cnt;
        for (i = 0; i < 80; i++)
        begin
            step();
            if (!ce)
            begin
                chk({file_rd, file_wr, acc_wr, pc_load, fetch_take}, 16'h0);
                continue;
            end
            cnt++;
            chk(phase_q, 16'((cnt - 1) % 4));
            chk(cycle_end, 16'(cnt % 4 == 0));
            if (cnt == 1)
                check_fields(w, e);
            if (cnt <= 4)
            begin
                chk(exec_nop_q, 16'h0);
                fw = fw + file_wr;
                aw = aw + acc_wr;
                pl = pl + pc_load;
            end
            else
                chk({exec_nop_q, file_rd, file_wr, acc_wr, pc_load}, 16'h10);
            if (fetch_take)
                break;
        end
        chk(16'(cnt), 16'(4 * e.cyc));
        if (e.rd >= 0)
            chk(rd_cnt - rd0, 16'(e.rd));
        if (e.fw >= 0)
            chk(fw, 16'(e.fw));
        if (e.aw >= 0)
            chk(aw, 16'(e.aw));
        if (e.pl >= 0)
            chk(pl, 16'(e.pl));
        if (i == 80)
        begin
            n_errors++;
            give_verdict();
        end
    endtask

    // Load a program, reset, then run it with the given pointer targets
    task automatic run_prog(input logic [1:0] pp);
        int k;
        int cnt;
        reset = 1'b1;
        ptr_prog = pp;
        for (k = 0; k < N; k++)
            prog[k] = make_word(k + ((pp == 2'h0) ? 0 : 20), $random(seed));
        for (k = 0; k <= N; k++)
        begin
            @(negedge clk);
            load_en = 1'b1;
            load_addr = 8'(k);
            load_data = (k < N) ? prog[k] : 14'h0000;
        end
        @(negedge clk);
        load_en = 1'b0;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        ce = 1'b1;
        cnt = 0;
        for (k = 0; k < 40 && !(ce && fetch_take); k++)
        begin
            step();
            cnt = cnt + int'(ce);
        end
        chk(16'(cnt), 16'h3);
        if (k == 40)
        begin
            n_errors++;
            give_verdict();
        end
        for (k = 0; k < N; k++)
        begin
            chk(instr_word, prog[k]);
            run_one(prog[k], pp);
            $display("test %0d.%0d word %h done", pp, k, prog[k]);
        end
    endtask

    // Main sequence: one program per pointer target setting
    initial
    begin
        reset = 1'b1;
        ce = 1'b1;
        ptr_prog = 2'h0;
        load_en = 1'b0;
        load_addr = 8'h00;
        load_data = 14'h0000;
        for (int p = 0; p < 4; p++)
            run_prog(2'(p));
        give_verdict();
    end
endmodule
`default_nettype wire
